// >>> hdl/ctrb_pkg.sv
/*
  Shared constants and types of the transformer ratio parameter bank.
  Assumes one core clock; all offsets are register indices on the plain port.
*/
package ctrb_pkg;

  localparam int DATA_W = 32;
  localparam int ADDR_W = 6;
  localparam int NUM_IN = 4;

  // Common ratio locations
  localparam logic [ADDR_W-1:0] OFS_PRI_ALL = 6'h00;
  localparam logic [ADDR_W-1:0] OFS_SEC_ALL = 6'h01;

  // Per-input ratio locations, input 1 to 4
  localparam logic [ADDR_W-1:0] OFS_PRI_IN [NUM_IN] = '{6'h0a, 6'h14, 6'h1e, 6'h28};
  localparam logic [ADDR_W-1:0] OFS_SEC_IN [NUM_IN] = '{6'h0b, 6'h15, 6'h1f, 6'h29};

  // Control, status and scaled result locations
  localparam logic [ADDR_W-1:0] OFS_CTRL = 6'h2c;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 6'h2d;
  localparam logic [ADDR_W-1:0] OFS_CUR_IN [NUM_IN] = '{6'h30, 6'h31, 6'h32, 6'h33};

  // Reset values
  localparam logic [DATA_W-1:0] RATIO_RST = 32'h0000_0005;
  localparam logic [NUM_IN-1:0] CTRL_RST = 4'hf;

  // Field positions
  localparam int CTRL_EN_LSB = 0;
  localparam int STAT_COMMON_BIT = 0;
  localparam int STAT_BUSY_LSB = 4;
  localparam int STAT_OVR_LSB = 8;

  // Divider length, one quotient bit per cycle
  localparam int DIV_STEPS = 64;

  typedef struct packed {
    logic [DATA_W-1:0] primary;
    logic [DATA_W-1:0] secondary;
  } ctrb_ratio_t;

  typedef struct packed {
    logic valid;
    logic [DATA_W-1:0] value;
  } ctrb_sample_t;

  typedef enum logic [1:0] {
    SC_IDLE = 2'b00,
    SC_DIV = 2'b01,
    SC_DONE = 2'b10
  } ctrb_sc_state_t;

endpackage : ctrb_pkg

// >>> hdl/ctrb_ratio_entry.sv
/*
  One input's primary/secondary ratio pair.
  Assumes load and write pulses come from the bank's decoder, never together.
*/
`timescale 1ns/1ps
module ctrb_ratio_entry (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic load_common_i,
  input wire ctrb_pkg::ctrb_ratio_t common_i,
  input wire logic wr_pri_i,
  input wire logic wr_sec_i,
  input wire logic [ctrb_pkg::DATA_W-1:0] wdata_i,
  output ctrb_pkg::ctrb_ratio_t ratio_o
);
  import ctrb_pkg::*;

  ctrb_ratio_t ratio_r;

  // Common copy overrides; a direct write lands otherwise
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ratio_r <= '{primary: RATIO_RST, secondary: RATIO_RST};
    end else if (load_common_i) begin
      ratio_r <= common_i;
    end else begin
      if (wr_pri_i) begin
        ratio_r.primary <= wdata_i;
      end
      if (wr_sec_i) begin
        ratio_r.secondary <= wdata_i;
      end
    end
  end

  assign ratio_o = ratio_r;

endmodule : ctrb_ratio_entry

// >>> hdl/ctrb_scaler.sv
/*
  Scales one secondary current sample by primary/secondary.
  Assumes samples come from logic on the core clock; one sample in flight.
*/
`timescale 1ns/1ps
module ctrb_scaler (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic en_i,
  input wire ctrb_pkg::ctrb_ratio_t ratio_i,
  input wire ctrb_pkg::ctrb_sample_t meas_i,
  output logic ready_o,
  output ctrb_pkg::ctrb_sample_t cur_o
);
  import ctrb_pkg::*;

  ctrb_sc_state_t state_r;
  logic [2*DATA_W-1:0] quo_r;
  logic [DATA_W:0] rem_r;
  logic [DATA_W-1:0] div_r;
  logic [6:0] step_r;
  logic bypass_r;
  logic [DATA_W:0] rem_sh;
  logic rem_ge;
  ctrb_sample_t cur_r;

  // Restoring division step: shift one dividend bit into remainder
  assign rem_sh = {rem_r[DATA_W-1:0], quo_r[2*DATA_W-1]};
  assign rem_ge = (rem_sh >= {1'b0, div_r});
  assign ready_o = (state_r == SC_IDLE);

  // Sequencer; product captured at start, then 64 divide steps
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      state_r <= SC_IDLE;
      quo_r <= '0;
      rem_r <= '0;
      div_r <= '0;
      step_r <= '0;
      bypass_r <= 1'b0;
    end else begin
      unique case (state_r)
        SC_IDLE: begin
          if (meas_i.valid) begin
            quo_r <= meas_i.value * ratio_i.primary;
            div_r <= ratio_i.secondary;
            rem_r <= '0;
            step_r <= '0;
            bypass_r <= !en_i;
            state_r <= en_i ? SC_DIV : SC_DONE;
            if (!en_i) begin
              quo_r <= {{DATA_W{1'b0}}, meas_i.value};
            end
          end
        end
        SC_DIV: begin
          rem_r <= rem_ge ? (rem_sh - {1'b0, div_r}) : rem_sh;
          quo_r <= {quo_r[2*DATA_W-2:0], rem_ge};
          step_r <= step_r + 7'h01;
          if (step_r == 7'(DIV_STEPS - 1)) begin
            state_r <= SC_DONE;
          end
        end
        SC_DONE: begin
          state_r <= SC_IDLE;
        end
        default: begin
          state_r <= SC_IDLE;
        end
      endcase
    end
  end

  // Scaled result saturates on overflow or a zero secondary; a bypassed sample passes as is
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      cur_r <= '0;
    end else begin
      cur_r.valid <= (state_r == SC_DONE);
      if (state_r == SC_DONE) begin
        if (!bypass_r && (div_r == '0 || quo_r[2*DATA_W-1:DATA_W] != '0)) begin
          cur_r.value <= '1;
        end else begin
          cur_r.value <= quo_r[DATA_W-1:0];
        end
      end
    end
  end

  assign cur_o = cur_r;

endmodule : ctrb_scaler

// >>> hdl/ctrb_bank.sv
/*
  Transformer ratio parameter bank for four current inputs, with
  common ratio copy, per-input clear of the common pair and current scaling.
  Assumes a register master on core_clk_i with one-cycle strobes and
  measured samples from logic on the same clock.
*/
// What this block does
// - Each of four current inputs keeps its own primary and secondary ratio value.
// - After reset every input, and the common pair, holds five to five.
// - Common primary sits at location 000, common secondary at 001.
// - Per-input pairs sit at 010 to 041: primary units zero, secondary units one.
// - Writing either common location copies both common values into all four entries.
// - Writing any per-input location clears both common locations.
// - Reported current is measured secondary current times primary over secondary.
`timescale 1ns/1ps
module ctrb_bank #(
  parameter int NUM_IN = ctrb_pkg::NUM_IN
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [ctrb_pkg::ADDR_W-1:0] addr_i,
  input wire logic [ctrb_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [ctrb_pkg::DATA_W-1:0] rdata_o,
  input wire ctrb_pkg::ctrb_sample_t meas_i [NUM_IN],
  output logic [NUM_IN-1:0] meas_ready_o,
  output ctrb_pkg::ctrb_sample_t cur_o [NUM_IN],
  output logic common_valid_o
);
  import ctrb_pkg::*;

  ctrb_ratio_t common_r;
  ctrb_ratio_t common_nxt;
  logic common_valid_r;
  logic wr_pri_all;
  logic wr_sec_all;
  logic load_common;
  logic [NUM_IN-1:0] wr_pri_in;
  logic [NUM_IN-1:0] wr_sec_in;
  logic wr_any_in;
  logic wr_ctrl;
  logic wr_status;
  logic [NUM_IN-1:0] ctrl_en_r;
  logic [NUM_IN-1:0] ovr_r;
  logic [NUM_IN-1:0] ovr_set;
  logic [NUM_IN-1:0] busy;
  ctrb_ratio_t ratio [NUM_IN];
  ctrb_sample_t cur [NUM_IN];
  logic [DATA_W-1:0] cur_hold_r [NUM_IN];
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rd_mux;
  logic [DATA_W-1:0] status_word;

  // Common, control and status location decode; only the write strobe qualifies
  assign wr_pri_all = wr_i && (addr_i == OFS_PRI_ALL);
  assign wr_sec_all = wr_i && (addr_i == OFS_SEC_ALL);
  assign load_common = wr_pri_all || wr_sec_all;
  assign wr_ctrl = wr_i && (addr_i == OFS_CTRL);
  assign wr_status = wr_i && (addr_i == OFS_STATUS);

  // Per-input decode, tens digit picks the input
  always_comb begin
    for (int i = 0; i < NUM_IN; i++) begin
      wr_pri_in[i] = wr_i && (addr_i == OFS_PRI_IN[i]);
      wr_sec_in[i] = wr_i && (addr_i == OFS_SEC_IN[i]);
    end
  end

  assign wr_any_in = |{wr_pri_in, wr_sec_in};

  // New common pair, so the copy carries the value just written
  always_comb begin
    common_nxt = common_r;
    if (wr_pri_all) begin
      common_nxt.primary = wdata_i;
    end
    if (wr_sec_all) begin
      common_nxt.secondary = wdata_i;
    end
  end

  // Common pair; a per-input write wipes it to zero
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      common_r <= '{primary: RATIO_RST, secondary: RATIO_RST};
    end else if (load_common) begin
      common_r <= common_nxt;
    end else if (wr_any_in) begin
      common_r <= '0;
    end
  end

  // Whether a shared ratio is currently stored
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      common_valid_r <= 1'b1;
    end else if (load_common) begin
      common_valid_r <= 1'b1;
    end else if (wr_any_in) begin
      common_valid_r <= 1'b0;
    end
  end

  assign common_valid_o = common_valid_r;

  // Per-input ratio storage and scaling
  for (genvar g = 0; g < NUM_IN; g++) begin : g_in
    ctrb_ratio_entry u_entry (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .load_common_i(load_common),
      .common_i(common_nxt),
      .wr_pri_i(wr_pri_in[g]),
      .wr_sec_i(wr_sec_in[g]),
      .wdata_i(wdata_i),
      .ratio_o(ratio[g])
    );

    ctrb_scaler u_scaler (
      .core_clk_i(core_clk_i),
      .rst_i(rst_i),
      .en_i(ctrl_en_r[g]),
      .ratio_i(ratio[g]),
      .meas_i(meas_i[g]),
      .ready_o(meas_ready_o[g]),
      .cur_o(cur[g])
    );

    assign busy[g] = !meas_ready_o[g];
    assign ovr_set[g] = meas_i[g].valid && busy[g];
    assign cur_o[g] = cur[g];
  end

  // Per-input scaling enable; disabled inputs pass samples unscaled
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ctrl_en_r <= CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_en_r <= wdata_i[CTRL_EN_LSB +: NUM_IN];
    end
  end

  // Overrun flags, write one to clear; a new overrun beats the clear
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ovr_r <= '0;
    end else begin
      ovr_r <= (ovr_r & ~(wr_status ? wdata_i[STAT_OVR_LSB +: NUM_IN] : '0)) | ovr_set;
    end
  end

  // Last scaled result per input, kept for software reads
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < NUM_IN; i++) begin
        cur_hold_r[i] <= '0;
      end
    end else begin
      for (int i = 0; i < NUM_IN; i++) begin
        if (cur[i].valid) begin
          cur_hold_r[i] <= cur[i].value;
        end
      end
    end
  end

  // Status word assembly
  always_comb begin
    status_word = '0;
    status_word[STAT_COMMON_BIT] = common_valid_r;
    status_word[STAT_BUSY_LSB +: NUM_IN] = busy;
    status_word[STAT_OVR_LSB +: NUM_IN] = ovr_r;
  end

  // Read mux; unmapped locations answer zero
  always_comb begin
    rd_mux = '0;
    if (addr_i == OFS_PRI_ALL) begin
      rd_mux = common_r.primary;
    end else if (addr_i == OFS_SEC_ALL) begin
      rd_mux = common_r.secondary;
    end else if (addr_i == OFS_CTRL) begin
      rd_mux[CTRL_EN_LSB +: NUM_IN] = ctrl_en_r;
    end else if (addr_i == OFS_STATUS) begin
      rd_mux = status_word;
    end else begin
      for (int i = 0; i < NUM_IN; i++) begin
        if (addr_i == OFS_PRI_IN[i]) begin
          rd_mux = ratio[i].primary;
        end
        if (addr_i == OFS_SEC_IN[i]) begin
          rd_mux = ratio[i].secondary;
        end
        if (addr_i == OFS_CUR_IN[i]) begin
          rd_mux = cur_hold_r[i];
        end
      end
    end
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rdata_r <= '0;
    end else begin
      rdata_r <= rd_i ? rd_mux : '0;
    end
  end

  assign rdata_o = rdata_r;

endmodule : ctrb_bank

// >>> sim/ctrb_bank_props.sv
/* Port checker for the ratio bank.
   Assumes one core clock with synchronous active-high reset. */
`timescale 1ns/1ps
module ctrb_bank_props #(
  parameter int NUM_IN = ctrb_pkg::NUM_IN
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic [ctrb_pkg::ADDR_W-1:0] addr_i,
  input wire logic [ctrb_pkg::DATA_W-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [ctrb_pkg::DATA_W-1:0] rdata_o,
  input wire ctrb_pkg::ctrb_sample_t meas_i [NUM_IN],
  input wire logic [NUM_IN-1:0] meas_ready_o,
  input wire ctrb_pkg::ctrb_sample_t cur_o [NUM_IN],
  input wire logic common_valid_o
);
  import ctrb_pkg::*;
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  logic in_wr;
  logic take0;
  // Per-input write and sample take decodes
  assign in_wr = wr_i && (addr_i inside {OFS_PRI_IN[0], OFS_SEC_IN[0], OFS_PRI_IN[1], OFS_SEC_IN[1],
    OFS_PRI_IN[2], OFS_SEC_IN[2], OFS_PRI_IN[3], OFS_SEC_IN[3]});
  assign take0 = meas_i[0].valid && meas_ready_o[0];
  sequence s_com_wr;
    wr_i && addr_i == OFS_PRI_ALL;
  endsequence
  sequence s_rd_in1;
    rd_i && addr_i == OFS_PRI_IN[0];
  endsequence
  AST_RD_IDLE: assert property (!rd_i |=> rdata_o == '0)
    else $error("read data not zero when idle");
  AST_COM_SET: assert property (wr_i && addr_i <= OFS_SEC_ALL |=> common_valid_o)
    else $error("common write did not store pair");
  AST_IN_CLR: assert property (in_wr |=> !common_valid_o)
    else $error("input write did not clear common pair");
  AST_CLR_RD0: assert property (rd_i && addr_i <= OFS_SEC_ALL && !common_valid_o |=> rdata_o == '0)
    else $error("cleared common location not zero");
  AST_COPY: assert property (s_com_wr ##2 s_rd_in1 |=> rdata_o == $past(wdata_i, 3))
    else $error("common primary not copied to input 1");
  AST_KEEP: assert property (!wr_i |=> $stable(common_valid_o))
    else $error("common flag moved without a write");
  AST_BUSY: assert property (take0 |=> !meas_ready_o[0])
    else $error("scaler ready after take");
  AST_CUR_LAT: assert property (take0 |-> ##[2:66] cur_o[0].valid)
    else $error("scaled current late");
  AST_CUR_PULSE: assert property (cur_o[0].valid |=> !cur_o[0].valid)
    else $error("result valid longer than one cycle");
endmodule : ctrb_bank_props

bind ctrb_bank ctrb_bank_props #(.NUM_IN(NUM_IN)) u_props (.core_clk_i(core_clk_i), .rst_i(rst_i),
  .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .meas_i(meas_i),
  .meas_ready_o(meas_ready_o), .cur_o(cur_o), .common_valid_o(common_valid_o));

// >>> sim/ctrb_bank_bench.sv
/* Self-checking bench for the ratio bank.
   Drives register port and samples itself; checker is bound separately. */
`timescale 1ns/1ps
module ctrb_bank_bench;
  import ctrb_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [ADDR_W-1:0] addr_i = '0;
  logic [DATA_W-1:0] wdata_i = '0;
  logic wr_i = 1'b0;
  logic rd_i = 1'b0;
  logic [DATA_W-1:0] rdata_o;
  ctrb_sample_t meas_i [NUM_IN];
  logic [NUM_IN-1:0] meas_ready_o;
  ctrb_sample_t cur_o [NUM_IN];
  logic common_valid_o;
  int num_errors = 0;
  int check_count = 0;
  integer seed = 55;
  logic [DATA_W-1:0] m_pri [NUM_IN];
  logic [DATA_W-1:0] m_sec [NUM_IN];
  logic [DATA_W-1:0] m_cp;
  logic [DATA_W-1:0] m_cs;
  logic m_cv;
  logic [NUM_IN-1:0] m_en;
  logic [NUM_IN-1:0] m_ovr;
  logic [DATA_W-1:0] m_cur [NUM_IN];

  // 200 MHz core clock
  always #2.5 core_clk_i = ~core_clk_i;

  ctrb_bank dut (.core_clk_i(core_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
    .rd_i(rd_i), .rdata_o(rdata_o), .meas_i(meas_i), .meas_ready_o(meas_ready_o), .cur_o(cur_o),
    .common_valid_o(common_valid_o));

  task automatic chk_v(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t value %h expected %h", $time, got, exp);
    end
  endtask : chk_v

  task automatic chk_f(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %0t flag %b expected %b", $time, got, exp);
    end
  endtask : chk_f

  // Expected readback from the shadow model; unmapped reads give zero
  function automatic logic [DATA_W-1:0] exp_of(input logic [ADDR_W-1:0] a);
    logic [DATA_W-1:0] r;
    r = '0;
    if (a == OFS_PRI_ALL) r = m_cp;
    if (a == OFS_SEC_ALL) r = m_cs;
    if (a == OFS_CTRL) r[CTRL_EN_LSB +: NUM_IN] = m_en;
    // Status is read only while every scaler is idle, so busy bits stay zero
    if (a == OFS_STATUS) begin
      r[STAT_COMMON_BIT] = m_cv;
      r[STAT_OVR_LSB +: NUM_IN] = m_ovr;
    end
    for (int k = 0; k < NUM_IN; k++) begin
      if (a == OFS_PRI_IN[k]) r = m_pri[k];
      if (a == OFS_SEC_IN[k]) r = m_sec[k];
      if (a == OFS_CUR_IN[k]) r = m_cur[k];
    end
    return r;
  endfunction : exp_of

  // Shadow state as reset leaves it
  task automatic model_reset;
    for (int k = 0; k < NUM_IN; k++) begin
      m_pri[k] = RATIO_RST;
      m_sec[k] = RATIO_RST;
      m_cur[k] = '0;
    end
    m_cp = RATIO_RST;
    m_cs = RATIO_RST;
    m_cv = 1'b1;
    m_en = CTRL_RST;
    m_ovr = '0;
  endtask : model_reset

  // One-cycle write, then shadow update with copy and clear effects
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge core_clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
    if (a == OFS_PRI_ALL) m_cp = d;
    if (a == OFS_SEC_ALL) m_cs = d;
    if (a <= OFS_SEC_ALL) m_cv = 1'b1;
    if (a == OFS_CTRL) m_en = d[CTRL_EN_LSB +: NUM_IN];
    if (a == OFS_STATUS) m_ovr = m_ovr & ~d[STAT_OVR_LSB +: NUM_IN];
    for (int k = 0; k < NUM_IN; k++) begin
      if (a <= OFS_SEC_ALL) begin
        m_pri[k] = m_cp;
        m_sec[k] = m_cs;
      end
      if (a == OFS_PRI_IN[k] || a == OFS_SEC_IN[k]) begin
        m_cp = '0;
        m_cs = '0;
        m_cv = 1'b0;
        if (a == OFS_PRI_IN[k]) m_pri[k] = d;
        else m_sec[k] = d;
      end
    end
  endtask : wr

  // Read data is looked at only in the cycle after the strobe
  task automatic rd(input logic [ADDR_W-1:0] a);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1;
    chk_v(rdata_o, exp_of(a));
  endtask : rd

  task automatic check_all;
    for (int k = 0; k < NUM_IN; k++) begin
      rd(OFS_PRI_IN[k]);
      rd(OFS_SEC_IN[k]);
      rd(OFS_CUR_IN[k]);
    end
    rd(OFS_PRI_ALL);
    rd(OFS_SEC_ALL);
    rd(OFS_CTRL);
    rd(OFS_STATUS);
    rd(6'h3f);
    chk_f(common_valid_o, m_cv);
  endtask : check_all

  // Send one sample through input k, a refused second one if ovr, and compare result and latency
  task automatic scale(input int k, input logic ovr);
    logic [DATA_W-1:0] v;
    logic [63:0] e;
    int n;
    v = $random(seed) & 32'hffff;
    if (m_en[k]) e = ({32'h0, v} * m_pri[k]) / m_sec[k];
    else e = {32'h0, v};
    @(posedge core_clk_i);
    meas_i[k] <= '{1'b1, v};
    @(posedge core_clk_i);
    meas_i[k] <= '{ovr, v}; // Lands while busy, so it is dropped
    for (n = 0; n < 200 && cur_o[k].valid !== 1'b1; n++) begin
      @(posedge core_clk_i);
      meas_i[k] <= '{1'b0, v};
      #1;
    end
    chk_f(cur_o[k].valid, 1'b1);
    chk_v(n, m_en[k] ? DIV_STEPS + 1 : 1);
    chk_v(cur_o[k].value, e[31:0]);
    m_cur[k] = e[31:0];
    if (ovr) m_ovr[k] = 1'b1;
    rd(OFS_CUR_IN[k]);
  endtask : scale

  task automatic final_report;
    $display("errors %0d checks %0d", num_errors, check_count);
    if (num_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report

  // Watchdog well beyond the roughly 1700 cycles the tests need
  initial begin
    repeat (20000) @(posedge core_clk_i);
    num_errors++;
    final_report();
  end

  initial begin
    int i;
    for (int k = 0; k < NUM_IN; k++) begin
      meas_i[k] = '0;
    end
    model_reset();
    repeat (20) @(posedge core_clk_i);
    rst_i <= 1'b0;
    check_all();
    wr(OFS_SEC_IN[1], $random(seed));
    check_all();
    wr(OFS_PRI_ALL, $random(seed));
    check_all();
    wr(6'h3f, $random(seed));
    // Random mix of common, per-input and unmapped writes
    repeat (30) begin
      i = $unsigned($random(seed)) % 11;
      if (i < 2) wr(i[ADDR_W-1:0], $random(seed));
      else if (i < 6) wr(OFS_PRI_IN[i-2], $random(seed));
      else if (i < 10) wr(OFS_SEC_IN[i-6], $random(seed));
      else wr(6'h05, $random(seed));
      check_all();
    end
    for (int k = 0; k < NUM_IN; k++) begin
      wr(OFS_PRI_IN[k], 32'h1 + ($random(seed) & 32'h3ff));
      wr(OFS_SEC_IN[k], 32'h1 + ($random(seed) & 32'h3f));
      scale(k, k[0]);
    end
    // Inputs 0 and 2 pass samples unscaled, each with a refused second sample
    wr(OFS_CTRL, 32'h0000_000a);
    for (int k = 0; k < NUM_IN; k++) begin
      scale(k, !k[0]);
    end
    rd(OFS_STATUS);
    wr(OFS_STATUS, 32'h0000_0500);
    rd(OFS_STATUS);
    // Reset in mid-run must bring every location back to its default
    @(posedge core_clk_i);
    rst_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    rst_i <= 1'b0;
    model_reset();
    check_all();
    final_report();
  end
endmodule : ctrb_bank_bench
